// ==== include/crb_pkg.sv ====
// Constants, field layout and state types for the chain readback sequencer.
// Assumes one monitor part on the serial chain, host and part on separate clocks.
// Contract
// R1 - Control bit D0 enables register readback
// R2 - Control D13:D12 both one suppress readback
// R3 - Host disables all, then enables one part
// R4 - Read-select address picks returned register
// R5 - Addressed read-select write changes matching part only
// R6 - Readback frame: 32 clocks per part, no-op
// R7 - Single-part readback serial clock below 1 MHz
// R8 - D15:D14 one, D13:D12 zero selects self-test
// R9 - Self-test address returns self-test result
// R10 - Gate value two accepts convert-start pin
// R11 - Falling convert-start edge begins conversion
// R12 - Host waits for conversions before gating, readback
// R13 - Gate value one blocks pin, loads outputs
// R14 - Control D7 enters, clearing leaves software reset
// R15 - Command word field layout, tail 010
// R16 - Broadcast or address match applies command
package crb_pkg;
    // Part register addresses
    localparam logic [5:0] CRB_REG_SELFTEST = 6'h0C;
    localparam logic [5:0] CRB_REG_CTRL_HI = 6'h0D;
    localparam logic [5:0] CRB_REG_CTRL_LO = 6'h0E;
    localparam logic [5:0] CRB_REG_RDSEL = 6'h1C;
    localparam logic [5:0] CRB_REG_GATE = 6'h1D;
    // Command word fields
    localparam int CRB_F_ADDR_LSB = 27;
    localparam int CRB_F_REG_LSB = 21;
    localparam int CRB_F_DATA_LSB = 13;
    localparam int CRB_F_WALL = 12;
    localparam int CRB_F_ZERO = 11;
    localparam logic [2:0] CRB_TAIL = 3'h2;
    localparam logic [31:0] CRB_NOP_WORD = 32'hF800030A;
    // Control bit positions within their bytes
    localparam int CRB_LO_RDEN = 0;
    localparam int CRB_LO_SRST = 7;
    localparam logic [1:0] CRB_HI_SEL_SELFTEST = 2'h3;
    localparam logic [1:0] CRB_HI_RD_OFF = 2'h3;
    localparam logic [7:0] CRB_GATE_PIN = 8'h02;
    localparam logic [7:0] CRB_GATE_BLOCK = 8'h01;
    // Reset values
    localparam logic [7:0] CRB_CTRL_HI_RST = 8'h00;
    localparam logic [7:0] CRB_CTRL_LO_RST = 8'h00;
    localparam logic [7:0] CRB_RDSEL_RST = 8'h00;
    localparam logic [7:0] CRB_GATE_RST = 8'h00;
    localparam logic [3:0] CRB_WORDS_RST = 4'h1;
    localparam int CRB_WORDS_MAX = 8;
    // Host register byte offsets on the Avalon slave
    localparam logic [4:0] CRB_H_CMD = 5'h00;
    localparam logic [4:0] CRB_H_STATUS = 5'h04;
    localparam logic [4:0] CRB_H_RXDATA = 5'h08;
    localparam logic [4:0] CRB_H_WORDS = 5'h0C;
    localparam logic [4:0] CRB_H_CONVERT = 5'h10;
    // Timing
    localparam int CRB_SYS_NS = 100;
    localparam int CRB_SCLK_HALF_NS = 800;
    localparam int CRB_SCLK_HALF_CYC = (CRB_SCLK_HALF_NS + CRB_SYS_NS - 1) / CRB_SYS_NS;
    localparam int CRB_CNV_LOW_NS = 500;
    localparam int CRB_CNV_LOW_CYC = (CRB_CNV_LOW_NS + CRB_SYS_NS - 1) / CRB_SYS_NS;
    localparam int CRB_CONV_CYC = 16;

    typedef enum logic [1:0] {
        CRB_ST_IDLE = 2'b00,
        CRB_ST_LOW = 2'b01,
        CRB_ST_HIGH = 2'b10,
        CRB_ST_TAIL = 2'b11
    } crb_host_st_t;
endpackage

// ==== include/crb_chain_if.sv ====
// Serial chain wires between host and monitor part.
// Assumes the bench joins both ends; all wires are push-pull.
`timescale 1ns/10ps
interface crb_chain_if;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic sdo;
    logic convert_start_pin_n;
    modport host_mp (output cs_n, output sclk, output sdi, output convert_start_pin_n, input sdo);
    modport dev_mp (input cs_n, input sclk, input sdi, input convert_start_pin_n, output sdo);
endinterface

// ==== core/crb_device.sv ====
// Monitor part end: command decode, registers, conversion, readback.
// Assumes sclk runs only inside frames; system clock runs free.
`timescale 1ns/10ps
module crb_device
    import crb_pkg::*;
#(
    parameter int CONV_CYCLES = CRB_CONV_CYC
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Chain
    crb_chain_if.dev_mp chain,
    // Part identity and analog stand-ins
    input wire logic [4:0] dev_addr_in,
    input wire logic [7:0] conv_value_in,
    input wire logic [7:0] selftest_value_in,
    // State
    output logic [7:0] ctrl_hi_out,
    output logic [7:0] ctrl_lo_out,
    output logic [7:0] rdsel_out,
    output logic [7:0] gate_out,
    output logic conv_busy_out,
    output logic soft_reset_out
);
    initial begin
        if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin
            $error("CONV_CYCLES out of range");
        end
    end

    typedef struct packed {
        logic [5:0] cnt;
        logic [31:0] insh;
        logic [31:0] outsh;
        logic sdo;
    } crb_bit_t;
    typedef struct packed {
        logic [31:0] cmd;
        logic tog;
    } crb_word_t;
    typedef struct packed {
        logic [2:0] tsync;
        logic tseen;
        logic [2:0] csync;
        logic cnv_lvl;
        logic [7:0] ctrl_hi;
        logic [7:0] ctrl_lo;
        logic [7:0] rdsel;
        logic [7:0] gate;
        logic [15:0] conv_cnt;
        logic busy;
        logic [7:0] result;
        logic [7:0] outreg;
        logic [31:0] word;
    } crb_sys_t;

    crb_bit_t b_q, b_d;
    crb_word_t w_q, w_d;
    crb_sys_t s_q, s_d;
    logic frame_rst_n;

    // Frame counter restarts when chip select rises
    assign frame_rst_n = reset_n_in & ~chain.cs_n;

    always_comb begin
        b_d = b_q;
        w_d = w_q;
        if (b_q.cnt < 6'd32) begin
            b_d.cnt = b_q.cnt + 6'd1;
            b_d.insh = {b_q.insh[30:0], chain.sdi};
            // R6 first 32 clocks carry readback
            if (b_q.cnt == 6'd0) begin
                b_d.sdo = s_q.word[31];
                b_d.outsh = {s_q.word[30:0], 1'b0};
            end else begin
                b_d.sdo = b_q.outsh[31];
                b_d.outsh = {b_q.outsh[30:0], 1'b0};
            end
            if (b_q.cnt == 6'd31) begin
                w_d.cmd = {b_q.insh[30:0], chain.sdi};
                w_d.tog = ~w_q.tog;
            end
        end else begin
            b_d.sdo = 1'b0;
        end
    end

    always_ff @(posedge chain.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            b_q <= '0;
        end else begin
            b_q <= b_d;
        end
    end

    // Word hold survives chip select so the toggle is never lost
    always_ff @(posedge chain.sclk or negedge reset_n_in) begin
        if (!reset_n_in) begin
            w_q <= '0;
        end else begin
            w_q <= w_d;
        end
    end

    always_comb begin
        logic [31:0] c;
        logic hit;
        logic cnv_fall;
        logic [7:0] rd;
        c = w_q.cmd;
        hit = 1'b0;
        cnv_fall = 1'b0;
        rd = 8'h00;
        s_d = s_q;
        s_d.tsync = {s_q.tsync[1:0], w_q.tog};
        s_d.csync = {s_q.csync[1:0], chain.convert_start_pin_n};
        if (s_q.csync[1] == s_q.csync[2]) begin
            s_d.cnv_lvl = s_q.csync[2];
            cnv_fall = s_q.cnv_lvl && !s_q.csync[2];
        end
        // Conversion
        if (s_q.busy) begin
            if (s_q.conv_cnt == 16'd1) begin
                s_d.busy = 1'b0;
                // R8 self-test sequence stores test value
                if (s_q.ctrl_hi[7:6] == CRB_HI_SEL_SELFTEST && s_q.ctrl_hi[5:4] == 2'b00) begin
                    s_d.result = selftest_value_in;
                end else begin
                    s_d.result = conv_value_in;
                end
            end
            s_d.conv_cnt = s_q.conv_cnt - 16'd1;
        end else if (cnv_fall && s_q.gate == CRB_GATE_PIN && !s_q.ctrl_lo[CRB_LO_SRST]) begin
            // R10 R11 pin edge starts conversion
            s_d.busy = 1'b1;
            s_d.conv_cnt = 16'(CONV_CYCLES);
        end
        // Command word crossed by toggle
        if (s_q.tsync[1] == s_q.tsync[2] && s_q.tsync[2] != s_q.tseen) begin
            s_d.tseen = s_q.tsync[2];
            // R16 broadcast or addressed
            hit = c[CRB_F_WALL] ? (c[31:CRB_F_ADDR_LSB] == 5'h00) : (c[31:CRB_F_ADDR_LSB] == dev_addr_in);
            // R15 reject malformed words
            if (c[2:0] != CRB_TAIL || c[CRB_F_ZERO]) begin
                hit = 1'b0;
            end
            if (hit) begin
                unique case (c[26:CRB_F_REG_LSB])
                    CRB_REG_CTRL_HI: s_d.ctrl_hi = c[20:CRB_F_DATA_LSB];
                    // R14 bit 7 enters and leaves reset
                    CRB_REG_CTRL_LO: s_d.ctrl_lo = c[20:CRB_F_DATA_LSB];
                    // R4 R5 read-select update
                    CRB_REG_RDSEL: s_d.rdsel = c[20:CRB_F_DATA_LSB];
                    CRB_REG_GATE: begin
                        s_d.gate = c[20:CRB_F_DATA_LSB];
                        // R13 blocking write loads outputs
                        if (c[20:CRB_F_DATA_LSB] == CRB_GATE_BLOCK) begin
                            s_d.outreg = s_q.result;
                        end
                    end
                    default: s_d.gate = s_q.gate;
                endcase
            end
        end
        // R14 held in reset while bit set
        if (s_d.ctrl_lo[CRB_LO_SRST]) begin
            s_d.ctrl_hi = CRB_CTRL_HI_RST;
            s_d.rdsel = CRB_RDSEL_RST;
            s_d.gate = CRB_GATE_RST;
            s_d.busy = 1'b0;
            s_d.result = 8'h00;
            s_d.outreg = 8'h00;
        end
        // R4 R9 selected register data
        unique case (s_q.rdsel[7:2])
            CRB_REG_SELFTEST: rd = s_q.outreg;
            CRB_REG_CTRL_HI: rd = s_q.ctrl_hi;
            CRB_REG_CTRL_LO: rd = s_q.ctrl_lo;
            CRB_REG_RDSEL: rd = s_q.rdsel;
            CRB_REG_GATE: rd = s_q.gate;
            default: rd = 8'h00;
        endcase
        // R1 R2 readback on unless suppressed
        if (s_q.ctrl_lo[CRB_LO_RDEN] && s_q.ctrl_hi[5:4] != CRB_HI_RD_OFF) begin
            s_d.word = {dev_addr_in, s_q.rdsel[7:2], rd, 13'h0000};
        end else begin
            s_d.word = 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '{tsync: 3'h0, tseen: 1'b0, csync: 3'h7, cnv_lvl: 1'b1,
                     ctrl_hi: CRB_CTRL_HI_RST, ctrl_lo: CRB_CTRL_LO_RST,
                     rdsel: CRB_RDSEL_RST, gate: CRB_GATE_RST, conv_cnt: 16'h0000,
                     busy: 1'b0, result: 8'h00, outreg: 8'h00, word: 32'h0000_0000};
        end else begin
            s_q <= s_d;
        end
    end

    assign chain.sdo = b_q.sdo;
    assign ctrl_hi_out = s_q.ctrl_hi;
    assign ctrl_lo_out = s_q.ctrl_lo;
    assign rdsel_out = s_q.rdsel;
    assign gate_out = s_q.gate;
    assign conv_busy_out = s_q.busy;
    assign soft_reset_out = s_q.ctrl_lo[CRB_LO_SRST];
endmodule

// ==== core/crb_host.sv ====
// Host end: Avalon-MM slave that frames commands and readback on the chain.
// Assumes software spaces conversions and readback; sclk made by divider.
`timescale 1ns/10ps
module crb_host
    import crb_pkg::*;
#(
    parameter int SCLK_HALF = CRB_SCLK_HALF_CYC,
    parameter int CNV_LOW = CRB_CNV_LOW_CYC
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Chain
    crb_chain_if.host_mp chain
);
    initial begin
        // Sync on sdo needs four cycles inside a half period
        if (SCLK_HALF < 4 || SCLK_HALF > 255 || CNV_LOW < 1 || CNV_LOW > 255) begin
            $error("crb_host timing parameters out of range");
        end
    end

    typedef struct packed {
        crb_host_st_t st;
        logic [7:0] div;
        logic [8:0] bitcnt;
        logic [3:0] words;
        logic [31:0] cmd;
        logic [31:0] tx;
        logic [31:0] rx;
        logic [2:0] sdo_sync;
        logic sdo_lvl;
        logic cs_n;
        logic sclk;
        logic sdi;
        logic cnv_n;
        logic [7:0] cnv_cnt;
        logic waitreq;
        logic [31:0] rdata;
    } crb_host_state_t;

    crb_host_state_t q, d;

    always_comb begin
        logic busy;
        logic stall;
        logic [8:0] last;
        busy = (q.st != CRB_ST_IDLE);
        stall = avs_write_in && avs_address_in == CRB_H_CMD && busy;
        last = {q.words, 5'h00} - 9'd1;
        d = q;
        d.sdo_sync = {q.sdo_sync[1:0], chain.sdo};
        if (q.sdo_sync[1] == q.sdo_sync[2]) begin
            d.sdo_lvl = q.sdo_sync[2];
        end
        if (q.div != 8'h00) begin
            d.div = q.div - 8'd1;
        end
        unique case (q.st)
            CRB_ST_IDLE: d.st = CRB_ST_IDLE;
            CRB_ST_LOW: begin
                if (q.div == 8'h00) begin
                    d.sclk = 1'b1;
                    d.div = 8'(SCLK_HALF - 1);
                    d.st = CRB_ST_HIGH;
                end
            end
            CRB_ST_HIGH: begin
                if (q.div == 8'h00) begin
                    d.sclk = 1'b0;
                    d.div = 8'(SCLK_HALF - 1);
                    if (q.bitcnt < 9'd32) begin
                        d.rx = {q.rx[30:0], q.sdo_lvl};
                    end
                    d.bitcnt = q.bitcnt + 9'd1;
                    if (q.bitcnt == last) begin
                        d.st = CRB_ST_TAIL;
                        d.sdi = 1'b0;
                    end else begin
                        d.st = CRB_ST_LOW;
                        // R6 later words carry the no-op
                        if (q.bitcnt[4:0] == 5'h1F) begin
                            d.tx = CRB_NOP_WORD;
                            d.sdi = CRB_NOP_WORD[31];
                        end else begin
                            d.tx = {q.tx[30:0], 1'b0};
                            d.sdi = q.tx[30];
                        end
                    end
                end
            end
            CRB_ST_TAIL: begin
                if (q.div == 8'h00) begin
                    d.cs_n = 1'b1;
                    d.st = CRB_ST_IDLE;
                end
            end
        endcase
        if (q.cnv_cnt != 8'h00) begin
            d.cnv_cnt = q.cnv_cnt - 8'd1;
        end else begin
            d.cnv_n = 1'b1;
        end
        // Bus: answer one cycle after request; a command write stalls while a frame runs
        if (q.waitreq) begin
            if ((avs_read_in || avs_write_in) && !stall) begin
                d.waitreq = 1'b0;
                unique case (avs_address_in)
                    CRB_H_CMD: d.rdata = q.cmd;
                    CRB_H_STATUS: d.rdata = {30'h0000_0000, !q.cnv_n, busy};
                    CRB_H_RXDATA: d.rdata = q.rx;
                    CRB_H_WORDS: d.rdata = {28'h000_0000, q.words};
                    default: d.rdata = 32'h0000_0000;
                endcase
            end
        end else begin
            d.waitreq = 1'b1;
            if (avs_write_in) begin
                unique case (avs_address_in)
                    CRB_H_CMD: begin
                        // R15 word sent as written, MSB first
                        d.cmd = avs_writedata_in;
                        d.tx = avs_writedata_in;
                        d.sdi = avs_writedata_in[31];
                        d.cs_n = 1'b0;
                        d.bitcnt = 9'd0;
                        d.div = 8'(SCLK_HALF - 1);
                        d.st = CRB_ST_LOW;
                    end
                    CRB_H_WORDS: begin
                        // R3 R6 one word per part read
                        if (avs_writedata_in[3:0] != 4'h0 && avs_writedata_in[3:0] <= 4'(CRB_WORDS_MAX)) begin
                            d.words = avs_writedata_in[3:0];
                        end
                    end
                    CRB_H_CONVERT: begin
                        if (avs_writedata_in[0]) begin
                            d.cnv_n = 1'b0;
                            d.cnv_cnt = 8'(CNV_LOW);
                        end
                    end
                    default: d.words = q.words;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= '{st: CRB_ST_IDLE, div: 8'h00, bitcnt: 9'h000, words: CRB_WORDS_RST,
                   cmd: 32'h0000_0000, tx: 32'h0000_0000, rx: 32'h0000_0000,
                   sdo_sync: 3'h0, sdo_lvl: 1'b0, cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0,
                   cnv_n: 1'b1, cnv_cnt: 8'h00, waitreq: 1'b1, rdata: 32'h0000_0000};
        end else begin
            q <= d;
        end
    end

    // R7 half period 800 ns keeps sclk below 1 MHz
    assign chain.sclk = q.sclk;
    assign chain.cs_n = q.cs_n;
    assign chain.sdi = q.sdi;
    assign chain.convert_start_pin_n = q.cnv_n;
    assign avs_readdata_out = q.rdata;
    assign avs_waitrequest_out = q.waitreq;
endmodule

// ==== verif/crb_props.sv ====
// Checker on the chain wires and the part state outputs.
// Assumes a divider half period of 8; the host holds the convert pin low 6 system cycles.
`timescale 1ns/10ps
module crb_props
    import crb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Chain
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic convert_start_pin_n,
    // Part state
    input wire logic [7:0] ctrl_hi_out,
    input wire logic [7:0] ctrl_lo_out,
    input wire logic [7:0] rdsel_out,
    input wire logic [7:0] gate_out,
    input wire logic conv_busy_out,
    input wire logic soft_reset_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence lead_s;
        !sclk [*8];
    endsequence
    sequence high_s;
        sclk [*8] ##1 !sclk;
    endsequence
    sequence pulse_s;
        !convert_start_pin_n [*6] ##1 convert_start_pin_n;
    endsequence
    sequence no_start_s;
        (!$rose(conv_busy_out)) [*8];
    endsequence

    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("sclk toggles outside a frame");
    sdo_idle_a: assert property (cs_n |-> !sdo)
        else $error("sdo driven outside a frame");
    cs_lead_a: assert property ($fell(cs_n) |-> lead_s)
        else $error("first sclk edge too early");
    sclk_half_a: assert property ($rose(sclk) |-> high_s)
        else $error("sclk high phase not 8 cycles");
    sdi_hold_a: assert property ((!cs_n && !$fell(cs_n) && !$fell(sclk)) |-> $stable(sdi))
        else $error("sdi moved away from a falling sclk");
    cnv_width_a: assert property ($fell(convert_start_pin_n) |-> pulse_s)
        else $error("convert pulse width wrong");
    conv_start_a: assert property (($fell(convert_start_pin_n) && gate_out == CRB_GATE_PIN && !conv_busy_out
        && !soft_reset_out) |-> ##[1:8] $rose(conv_busy_out))
        else $error("conversion did not start");
    conv_gate_a: assert property ($rose(conv_busy_out) |-> gate_out == CRB_GATE_PIN)
        else $error("conversion started while not enabled");
    conv_block_a: assert property (($fell(convert_start_pin_n) && gate_out != CRB_GATE_PIN) |-> no_start_s)
        else $error("gated pin started a conversion");
    soft_hold_a: assert property ((soft_reset_out && $past(soft_reset_out)) |->
        {ctrl_hi_out, rdsel_out, gate_out} == 24'h000000)
        else $error("registers not held in soft reset");
    reg_frame_a: assert property ((!$stable(ctrl_hi_out) || !$stable(ctrl_lo_out) || !$stable(rdsel_out)
        || !$stable(gate_out)) |-> !cs_n)
        else $error("register changed outside a frame");
endmodule

// ==== verif/chain_register_readback_sequencer_tb.sv ====
// Bench joining host and part over the chain, driving the Avalon side.
// Assumes default timing parameters; part address and values are random.
`timescale 1ns/10ps
module chain_register_readback_sequencer_tb;
    import crb_pkg::*;
    localparam int LIMIT = 60000;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [4:0] dev_addr = 5'h01;
    logic [7:0] conv_value = 8'h00;
    logic [7:0] selftest_value = 8'h00;
    logic [7:0] ctrl_hi;
    logic [7:0] ctrl_lo;
    logic [7:0] rdsel;
    logic [7:0] gate;
    logic conv_busy;
    logic soft_reset;
    logic [31:0] rng = 32'h15C0;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    crb_chain_if chain_if ();
    crb_host u_crb_host (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .avs_address_in(avs_address),
        .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest), .chain(chain_if.host_mp));
    crb_device u_crb_device (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .chain(chain_if.dev_mp),
        .dev_addr_in(dev_addr), .conv_value_in(conv_value), .selftest_value_in(selftest_value),
        .ctrl_hi_out(ctrl_hi), .ctrl_lo_out(ctrl_lo), .rdsel_out(rdsel), .gate_out(gate),
        .conv_busy_out(conv_busy), .soft_reset_out(soft_reset));
    crb_props u_crb_props (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .cs_n(chain_if.cs_n),
        .sclk(chain_if.sclk), .sdi(chain_if.sdi), .sdo(chain_if.sdo),
        .convert_start_pin_n(chain_if.convert_start_pin_n),
        .ctrl_hi_out(ctrl_hi), .ctrl_lo_out(ctrl_lo), .rdsel_out(rdsel), .gate_out(gate),
        .conv_busy_out(conv_busy), .soft_reset_out(soft_reset));

    always #50 sys_clk = ~sys_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // CRC field left zero: the part does not check it
    function automatic logic [31:0] cmd(input logic [4:0] a, input logic [5:0] r, input logic [7:0] d,
        input logic w);
        return {a, r, d, w, 1'b0, 8'h00, CRB_TAIL};
    endfunction
    function automatic logic [31:0] rb_word(input logic [7:0] sel, input logic [7:0] d);
        return {dev_addr, sel[7:2], d, 13'h0000};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic send(input logic [31:0] w);
        logic [31:0] q;
        bus(1'b1, CRB_H_CMD, w, q);
        do bus(1'b0, CRB_H_STATUS, 32'h0, q); while (q[0] !== 1'b0);
    endtask
    task automatic readback(output logic [31:0] q);
        send(CRB_NOP_WORD);
        bus(1'b0, CRB_H_RXDATA, 32'h0, q);
    endtask
    task automatic pulse(output logic started);
        logic [31:0] q;
        int n;
        bus(1'b1, CRB_H_CONVERT, 32'h1, q);
        bus(1'b0, CRB_H_STATUS, 32'h0, q);
        check(q[1], 1'b1);
        n = 0;
        while (conv_busy !== 1'b1 && n < 30) begin
            @(negedge sys_clk);
            n++;
        end
        started = conv_busy;
        while (conv_busy !== 1'b0 && n < 70) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        logic [31:0] q;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] sel;
        logic st;
        repeat (12) @(posedge sys_clk);
        rng = xs(rng);
        dev_addr <= 5'(rng % 30 + 1);
        conv_value <= rng[15:8];
        selftest_value <= ~rng[15:8];
        reset_n <= 1'b1;
        @(posedge sys_clk);
        check({ctrl_hi, ctrl_lo, rdsel, gate}, {CRB_CTRL_HI_RST, CRB_CTRL_LO_RST, CRB_RDSEL_RST, CRB_GATE_RST});
        bus(1'b1, CRB_H_WORDS, 32'h9, q);
        bus(1'b1, 5'h14, 32'hFFFFFFFF, q);
        bus(1'b0, 5'h14, 32'h0, q);
        check(q, 32'h0);
        bus(1'b0, CRB_H_WORDS, 32'h0, q);
        check(q, 32'(CRB_WORDS_RST));
        $display("Test reset and host registers done");
        send(cmd(5'h00, CRB_REG_CTRL_LO, 8'h15, 1'b1));
        check(ctrl_lo, 8'h15);
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            hi = rng[7:0] & 8'hDF;
            lo = (rng[15:8] | 8'h01) & 8'h7F;
            sel = {(i[0] ? CRB_REG_CTRL_LO : CRB_REG_CTRL_HI), 2'b00};
            send(cmd(5'h00, CRB_REG_CTRL_HI, hi, 1'b1));
            send(cmd(5'h00, CRB_REG_CTRL_LO, lo, 1'b1));
            send(cmd(5'h00, CRB_REG_RDSEL, sel, 1'b1));
            check({ctrl_hi, ctrl_lo, rdsel}, {hi, lo, sel});
            readback(q);
            check(q, rb_word(sel, i[0] ? lo : hi));
        end
        $display("Test broadcast readback done");
        send(cmd(5'h00, CRB_REG_CTRL_HI, 8'h30, 1'b1));
        readback(q);
        check(q, 32'h0);
        send(cmd(dev_addr ^ 5'h10, CRB_REG_RDSEL, 8'h34, 1'b0));
        check(rdsel, sel);
        send(cmd(5'h00, CRB_REG_CTRL_HI, 8'h01, 1'b1) ^ 32'h00000800);
        send(cmd(5'h00, CRB_REG_CTRL_HI, 8'h02, 1'b1) ^ 32'h00000001);
        check(ctrl_hi, 8'h30);
        bus(1'b0, CRB_H_CMD, 32'h0, q);
        check(q, cmd(5'h00, CRB_REG_CTRL_HI, 8'h02, 1'b1) ^ 32'h00000001);
        send(cmd(dev_addr, CRB_REG_CTRL_HI, 8'h40, 1'b0));
        send(cmd(dev_addr, CRB_REG_RDSEL, 8'h34, 1'b0));
        readback(q);
        check(q, rb_word(8'h34, 8'h40));
        $display("Test single part readback done");
        for (int m = 0; m < 2; m++) begin
            send(cmd(5'h00, CRB_REG_CTRL_HI, m ? 8'hC0 : 8'h40, 1'b1));
            pulse(st);
            check(st, 1'b0);
            send(cmd(5'h00, CRB_REG_GATE, CRB_GATE_PIN, 1'b1));
            pulse(st);
            check(st, 1'b1);
            send(cmd(5'h00, CRB_REG_GATE, CRB_GATE_BLOCK, 1'b1));
            pulse(st);
            check(st, 1'b0);
            send(cmd(5'h00, CRB_REG_RDSEL, {CRB_REG_SELFTEST, 2'b00}, 1'b1));
            readback(q);
            check(q, rb_word({CRB_REG_SELFTEST, 2'b00}, m ? selftest_value : conv_value));
        end
        $display("Test conversions done");
        send(cmd(5'h00, CRB_REG_CTRL_LO, 8'h95, 1'b1));
        check({soft_reset, ctrl_hi, rdsel, gate}, {1'b1, 24'h000000});
        send(cmd(5'h00, CRB_REG_CTRL_HI, 8'h40, 1'b1));
        check(ctrl_hi, 8'h00);
        send(cmd(5'h00, CRB_REG_CTRL_LO, 8'h15, 1'b1));
        send(cmd(5'h00, CRB_REG_CTRL_HI, 8'h40, 1'b1));
        check({soft_reset, ctrl_hi}, {1'b0, 8'h40});
        $display("Test software reset done");
        print_verdict();
    end
endmodule
